// >>> core/timer8_counter_compare.sv
// 8-bit timer/counter with two compares and Avalon-MM registers
`timescale 1ns/10ps
// What this block does
// - Reserved control, mask, flag bits read zero
// - Mode bit: Normal top 0xFF, else clear-on-match
// - Compare writes take effect at once
// - Overflow flag set when counter passes 0xFF
// - Source code zero stops the counter
// - Codes 1..5 pick divide 1,8,64,256,1024
// - Code 6 falling, 7 rising pin edges
// - Pin counts even when driven as output
// - Count register directly readable and writable
// - Count write blocks match on next tick
// - Each compare continuously equals-tests the count
// - Request when enable, flag, global bit set
// - Compare B match sets its flag in either mode unless blocked
// - Vector execution clears its flag
// - Writing one clears a flag, zero keeps
// - Clear-on-match: A match sets flag, clears count
// - Every overflow sets the overflow flag
// - Tick is a clock enable, one clock
// - Compare flag set on tick after match
// - Overflow flag set on the wrap tick
// - Count write beats count or clear
module timer8_counter_compare (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Register bus
    input  wire timer8_pkg::avmm_req_t avm_req,
    output timer8_pkg::avmm_rsp_t     avm_rsp,
    // External count pin
    input  wire logic                 external_count_pin,
    // CPU interrupt side
    input  wire logic                 global_irq_enable,
    input  wire logic [2:0]           irq_ack,
    output logic [2:0]                irq_request
);
    import timer8_pkg::*;

    ////////////////////////////////////////////////////////////
    // Declarations
    timer_state_t         st;        // Registered state
    timer_state_t         next_st;   // Next state
    logic [NUM_TAPS-1:0]  taps;      // Prescaler pulses
    logic                 ext_rise;  // Pin rising edge
    logic                 ext_fall;  // Pin falling edge
    logic                 tick;      // Timer tick enable
    logic                 match_a;   // Count equals compare A
    logic                 match_b;   // Count equals compare B
    logic                 hit_a;     // Unblocked match A on tick
    logic                 hit_b;     // Unblocked match B on tick
    logic                 wrap;      // Tick while at MAX
    logic                 wr_en;     // Accepted write, low lane
    logic                 rd_take;   // Read served this cycle
    logic                 cnt_wr;    // Software writes count
    logic [2:0]           set_v;     // Flag set events
    logic [2:0]           clr_v;     // Flag clear requests
    logic [31:0]          rd_mux;    // Selected read word

    ////////////////////////////////////////////////////////////
    // Shared prescaler
    timer8_prescaler #(
        .WIDTH (PRE_W)
    ) u_presc (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .tap_pulse (taps)
    );

    // Pin synchroniser and edge detector
    timer8_edge_sync u_pin (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (external_count_pin),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    ////////////////////////////////////////////////////////////
    // Clock source selection; result is an enable, not a clock
    // so the whole timer stays in one clock domain
    always_comb begin
        case (st.cs)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = taps[0];
            CS_DIV64:    tick = taps[1];
            CS_DIV256:   tick = taps[2];
            CS_DIV1024:  tick = taps[3];
            // Pin direction is not looked at, so a driven
            // output still counts
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default:     tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Comparators run every cycle; flags are only set on a tick
    assign match_a = (st.count == st.cmp_a);
    assign match_b = (st.count == st.cmp_b);
    assign hit_a   = tick & match_a & ~st.block;
    assign hit_b   = tick & match_b & ~st.block;
    assign wrap    = tick & (st.count == COUNT_MAX);

    ////////////////////////////////////////////////////////////
    // Bus decode; writes never wait, low byte lane carries data
    assign wr_en   = avm_req.write & avm_req.byteenable[0];
    assign rd_take = avm_req.read & ~st.rd_done;
    assign cnt_wr  = wr_en & (avm_req.address == IDX_COUNT);

    // Flag events; hardware set beats any clear
    assign set_v = {hit_b, hit_a, wrap};
    always_comb begin
        clr_v = irq_ack;
        if (wr_en && avm_req.address == IDX_FLAG) begin
            clr_v = clr_v | avm_req.writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////
    // Read multiplexer; unused and reserved bits read zero
    always_comb begin
        rd_mux = '0;
        case (avm_req.address)
            IDX_CTRL: begin
                rd_mux[CTC_BIT] = st.clear_on_match_mode;
                rd_mux[2:0]     = st.cs;
            end
            IDX_COUNT: begin
                rd_mux[7:0] = st.count;
            end
            IDX_CMP_A: begin
                rd_mux[7:0] = st.cmp_a;
            end
            IDX_CMP_B: begin
                rd_mux[7:0] = st.cmp_b;
            end
            IDX_MASK: begin
                rd_mux[2:0] = st.mask;
            end
            IDX_FLAG: begin
                rd_mux[2:0] = st.flags;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Next-state logic for the whole core
    always_comb begin
        next_st = st;

        // Counter advances only on the tick enable
        if (tick) begin
            if (st.clear_on_match_mode && hit_a) begin
                next_st.count = RST_BYTE;
            end else begin
                next_st.count = st.count + 8'h01;
            end
        end

        // Block lasts until the next tick, even when stopped
        if (tick) begin
            next_st.block = 1'b0;
        end

        // Flags: set wins over clear in the same cycle
        next_st.flags = (st.flags & ~clr_v) | set_v;

        // Register writes
        if (wr_en) begin
            case (avm_req.address)
                IDX_CTRL: begin
                    next_st.clear_on_match_mode = avm_req.writedata[CTC_BIT];
                    next_st.cs  = clk_src_t'(avm_req.writedata[2:0]);
                end
                IDX_COUNT: begin
                    // Software value beats count and clear
                    next_st.count = avm_req.writedata[7:0];
                    next_st.block = 1'b1;
                end
                IDX_CMP_A: begin
                    // No shadow copy: used from next cycle
                    next_st.cmp_a = avm_req.writedata[7:0];
                end
                IDX_CMP_B: begin
                    next_st.cmp_b = avm_req.writedata[7:0];
                end
                IDX_MASK: begin
                    next_st.mask = avm_req.writedata[2:0];
                end
                default: begin
                    next_st.clear_on_match_mode = st.clear_on_match_mode;
                end
            endcase
        end

        // Reads take one wait state; data held until the next
        next_st.rd_done = rd_take;
        if (rd_take) begin
            next_st.readdata = rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////
    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st          <= '0;
            st.cs       <= CS_STOP;
            st.count    <= RST_BYTE;
            st.cmp_a    <= RST_BYTE;
            st.cmp_b    <= RST_BYTE;
            st.mask     <= RST_IRQ;
            st.flags    <= RST_IRQ;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////
    // Outputs
    assign avm_rsp.readdata    = st.readdata;
    assign avm_rsp.waitrequest = avm_req.read & ~st.rd_done;

    // Gated requests, one per source
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
        assign irq_request[i] = global_irq_enable
                              & st.mask[i]
                              & st.flags[i];
    end

    ////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_reserved_zero: assert property (
        (rd_take && avm_req.address == IDX_CTRL)
        |=> (avm_rsp.readdata[31:4] == 28'h0000000))
        else $error("reserved control bits not zero");

    a_stop_holds: assert property (
        (st.cs == CS_STOP && !cnt_wr)
        |=> (st.count == $past(st.count)))
        else $error("stopped counter moved");

    a_normal_step: assert property (
        (tick && !st.clear_on_match_mode && !cnt_wr)
        |=> (st.count == 8'($past(st.count) + 8'h01)))
        else $error("normal mode did not increment");

    a_ctc_clear: assert property (
        (tick && st.clear_on_match_mode && match_a && !st.block && !cnt_wr)
        |=> (st.count == 8'h00 && st.flags[FLG_CMPA]))
        else $error("clear-on-match failed");

    a_ovf_wrap: assert property (
        (tick && st.count == COUNT_MAX)
        |=> st.flags[FLG_OVF])
        else $error("overflow flag not set on wrap");

    a_cnt_write: assert property (
        cnt_wr
        |=> (st.count == $past(avm_req.writedata[7:0])
             && st.block))
        else $error("count write lost");

    a_match_block: assert property (
        (st.block && tick && !hit_b && clr_v == 3'h0)
        |=> (st.flags == ($past(st.flags) | {2'h0, $past(wrap)})))
        else $error("blocked match changed flags");

    a_cmp_b_flag: assert property (
        (tick && match_b && !st.block) |=> st.flags[FLG_CMPB])
        else $error("compare B flag not set");

    a_ack_clear: assert property (
        (irq_ack[FLG_OVF] && !wrap)
        |=> !st.flags[FLG_OVF])
        else $error("acknowledge did not clear overflow flag");

    a_read_answer: assert property (
        (avm_req.read && !st.rd_done)
        |-> avm_rsp.waitrequest ##1 !avm_rsp.waitrequest)
        else $error("read not answered in one wait state");

    // Reserved mask and flag bits must read zero too
    a_mask_zero: assert property (
        (rd_take && avm_req.address == IDX_MASK)
        |=> (avm_rsp.readdata[31:3] == 29'h0))
        else $error("reserved mask bits not zero");

    a_flag_zero: assert property (
        (rd_take && avm_req.address == IDX_FLAG)
        |=> (avm_rsp.readdata[31:3] == 29'h0))
        else $error("reserved flag bits not zero");

    // No shadow register: the value is live one edge later
    a_cmp_write: assert property (
        (wr_en && avm_req.address == IDX_CMP_A)
        |=> (st.cmp_a == $past(avm_req.writedata[7:0])))
        else $error("compare A write not immediate");

    // Overflow flag rises only on a tick at MAX
    a_ovf_only: assert property (
        (!st.flags[FLG_OVF] && !(tick && st.count == COUNT_MAX))
        |=> !st.flags[FLG_OVF])
        else $error("overflow flag set off the wrap");

    // Divide-by-8 pulse is followed by seven quiet cycles
    a_div8_gap: assert property (
        taps[0] |=> (!taps[0])[*7])
        else $error("divide by 8 pulse spacing wrong");

    // A falling pin edge advances the count by one
    a_ext_fall: assert property (
        (st.cs == CS_EXT_FALL && ext_fall && !st.clear_on_match_mode && !cnt_wr)
        |=> (st.count == 8'($past(st.count) + 8'h01)))
        else $error("falling pin edge not counted");

    // A one written to a flag bit clears it unless set again
    a_flag_clear: assert property (
        (wr_en && avm_req.address == IDX_FLAG
         && avm_req.writedata[FLG_CMPA] && !hit_a)
        |=> !st.flags[FLG_CMPA])
        else $error("write one did not clear flag A");

    // Unblocked compare A match sets its flag in either mode
    a_cmp_a_flag: assert property (
        (tick && match_a && !st.block) |=> st.flags[FLG_CMPA])
        else $error("compare A flag not set");

endmodule

// >>> core/timer8_pkg.sv
// Shared constants and types for the 8-bit timer/counter
package timer8_pkg;

    ////////////////////////////////////////////////////////////
    // Register word indices; byte address is four times these
    localparam logic [7:0] IDX_CTRL  = 8'h24;
    localparam logic [7:0] IDX_COUNT = 8'h26;
    localparam logic [7:0] IDX_CMP_A = 8'h27;
    localparam logic [7:0] IDX_CMP_B = 8'h28;
    localparam logic [7:0] IDX_MASK  = 8'h29;
    localparam logic [7:0] IDX_FLAG  = 8'h2a;

    ////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTC_BIT  = 3;
    localparam int unsigned FLG_OVF  = 0;
    localparam int unsigned FLG_CMPA = 1;
    localparam int unsigned FLG_CMPB = 2;
    localparam int unsigned NUM_IRQ  = 3;

    ////////////////////////////////////////////////////////////
    // Values and reset values
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [2:0] RST_IRQ   = 3'h0;

    ////////////////////////////////////////////////////////////
    // Prescaler width and tap widths (divide by 2**tap)
    localparam int unsigned PRE_W    = 10;
    localparam int unsigned NUM_TAPS = 4;
    localparam int unsigned TAP_BITS [NUM_TAPS] = '{3, 6, 8, 10};

    // Clock source codes
    typedef enum logic [2:0] {
        CS_STOP     = 3'h0,
        CS_DIV1     = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_src_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avmm_req_t;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avmm_rsp_t;

    // Whole state of the timer core
    typedef struct packed {
        logic        clear_on_match_mode;
        clk_src_t    cs;
        logic [7:0]  count;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic [2:0]  mask;
        logic [2:0]  flags;
        logic        block;
        logic        rd_done;
        logic [31:0] readdata;
    } timer_state_t;

    // Prescaler state
    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } presc_state_t;

    // Pin synchroniser state
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } sync_state_t;

endpackage

// >>> core/timer8_prescaler.sv
// Free-running prescaler giving divided tick pulses
`timescale 1ns/10ps
module timer8_prescaler #(
    parameter int unsigned WIDTH = timer8_pkg::PRE_W
) (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    // One-cycle pulses at /8, /64, /256, /1024
    output logic [timer8_pkg::NUM_TAPS-1:0]      tap_pulse
);
    import timer8_pkg::*;

    presc_state_t st;       // Registered state
    presc_state_t next_st;  // Next state

    ////////////////////////////////////////////////////////////
    // Runs free, so every timer sharing it stays in phase
    always_comb begin
        next_st = st;
        next_st.cnt = st.cnt + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////
    // One tap per division ratio, pulse when low bits all ones
    for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
        assign tap_pulse[i] = &st.cnt[TAP_BITS[i]-1:0];
    end

endmodule

// >>> core/timer8_edge_sync.sv
// Synchroniser and edge detector for the external count pin
`timescale 1ns/10ps
module timer8_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Raw pin level
    input  wire logic pin,
    // One-cycle edge pulses
    output logic      rise,
    output logic      fall
);
    import timer8_pkg::*;

    sync_state_t st;       // Registered state
    sync_state_t next_st;  // Next state

    ////////////////////////////////////////////////////////////
    // Two flops, then a third for edge history; meta feeds
    // nothing but the second flop
    always_comb begin
        next_st = st;
        next_st.meta   = pin;
        next_st.stable = st.meta;
        next_st.last   = st.stable;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Edges seen only on the settled copy
    assign rise = st.stable & ~st.last;
    assign fall = ~st.stable & st.last;

endmodule

// >>> tb/timer8_counter_compare_test.sv
// Self-checking testbench for the 8-bit timer/counter
`timescale 1ns/10ps
module timer8_counter_compare_test;
    import timer8_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // One row: register index, byte written, byte expected on read back
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } reg_row_t;

    logic       clk;           // System clock, 50 ns period
    logic       sys_rst;       // Synchronous reset, active high
    avmm_req_t  avm_req;       // Bus request driven by the bench
    avmm_rsp_t  avm_rsp;       // Bus answer from the block
    logic       count_pin;     // External count pin level
    logic       global_irq;    // CPU global interrupt bit
    logic [2:0] irq_ack;       // Vector executed pulses
    logic [2:0] irq_request;   // Interrupt requests seen
    logic [3:0] be;            // Byte enables for the next write
    logic [7:0] rd;            // Last byte read
    int         fail_count;    // Mismatches counted
    int         checks_done;   // Comparisons made
    int         cycles;        // Cycles run, for the timeout
    reg_row_t   rows [7];      // Ordinary register cases
    int         divs [5] = '{1, 8, 64, 256, 1024};  // Source divide ratios

    ////////////////////////////////////////////////////////////////////////
    // Device under test
    timer8_counter_compare dut (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .avm_req            (avm_req),
        .avm_rsp            (avm_rsp),
        .external_count_pin (count_pin),
        .global_irq_enable  (global_irq),
        .irq_ack            (irq_ack),
        .irq_request        (irq_request)
    );

    // Clock: invert every half period
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Timeout: whole run is about 5900 cycles, so 20000 means a hang
    initial cycles = 0;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected at %0t: timeout", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, seen, exp);
        end
    endtask

    // Bus write; an idle edge follows so write never toggles in one step
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        avm_req.address    <= idx;
        avm_req.writedata  <= {24'h000000, data};
        avm_req.byteenable <= be;
        avm_req.write      <= 1'b1;
        do @(posedge clk); while (avm_rsp.waitrequest !== 1'b0);
        avm_req.write <= 1'b0;
        @(posedge clk);
    endtask

    // Bus read; data is taken at the edge where waitrequest is low
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] data);
        avm_req.address <= idx;
        avm_req.read    <= 1'b1;
        do @(posedge clk); while (avm_rsp.waitrequest !== 1'b0);
        data = avm_rsp.readdata[7:0];
        avm_req.read <= 1'b0;
        @(posedge clk);
    endtask

    // Read a register and compare it
    task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp,
                              input string what);
        logic [7:0] v;
        rd_reg(idx, v);
        check(v, exp, what);
    endtask

    // Start the timer, wait n edges, stop it: n+2 ticking edges in all
    task automatic run(input logic [7:0] ctrl, input int n);
        wr(IDX_CTRL, ctrl);
        repeat (n) @(posedge clk);
        wr(IDX_CTRL, ctrl & 8'h08);
    endtask

    // Hold reset for 20 cycles, then let one edge see it low
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask

    // Closing report and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst     = 1'b1;
        avm_req     = '0;
        count_pin   = 1'b0;
        global_irq  = 1'b0;
        irq_ack     = 3'h0;
        be          = 4'h1;
        fail_count  = 0;
        checks_done = 0;
        rows[0] = '{IDX_CTRL,  8'hf8, 8'h08};
        rows[1] = '{IDX_COUNT, 8'h3c, 8'h3c};
        rows[2] = '{IDX_CMP_A, 8'ha5, 8'ha5};
        rows[3] = '{IDX_CMP_B, 8'h5a, 8'h5a};
        rows[4] = '{IDX_MASK,  8'hff, 8'h07};
        rows[5] = '{IDX_FLAG,  8'hff, 8'h00};
        rows[6] = '{8'h30,     8'hff, 8'h00};
        @(posedge clk);
        do_reset();
        // Every register reads zero after reset
        for (int i = 0; i < 6; i++) begin
            expect_reg(rows[i].idx, 8'h00, "reset value");
        end
        // Table of write and read-back cases, unmapped index last
        for (int i = 0; i < 7; i++) begin
            wr(rows[i].idx, rows[i].wdata);
            rd_reg(rows[i].idx, rd);
            check(rd, rows[i].rexp, "read back");
        end
        $display("test registers done");

        // Stopped source leaves the count alone; disabled lanes ignored
        be = 4'h0;
        wr(IDX_COUNT, 8'h77);
        be = 4'h1;
        run(8'h00, 30);
        expect_reg(IDX_COUNT, 8'h3c, "stopped count");
        $display("test stopped done");

        // Normal mode wraps past 0xff: 30 ticks from 0xf0 end at 0x0e
        wr(IDX_CMP_A, 8'h05);
        wr(IDX_CMP_B, 8'hf8);
        wr(IDX_COUNT, 8'hf0);
        run(8'h01, 28);
        expect_reg(IDX_COUNT, 8'h0e, "normal count");
        expect_reg(IDX_FLAG, 8'h07, "normal flags");
        $display("test normal done");

        // Requests need enable, flag and global bit together
        global_irq <= 1'b1;
        wr(IDX_MASK, 8'h07);
        check({5'h00, irq_request}, 8'h07, "irq all");
        global_irq <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check({5'h00, irq_request}, 8'h00, "irq global off");
        global_irq <= 1'b1;
        irq_ack    <= 3'h1;
        @(posedge clk);
        irq_ack <= 3'h0;
        expect_reg(IDX_FLAG, 8'h06, "vector clear");
        wr(IDX_FLAG, 8'h02);
        expect_reg(IDX_FLAG, 8'h04, "write one clear");
        wr(IDX_FLAG, 8'h00);
        expect_reg(IDX_FLAG, 8'h04, "write zero keep");
        wr(IDX_MASK, 8'h03);
        check({5'h00, irq_request}, 8'h00, "irq masked");
        wr(IDX_MASK, 8'h04);
        check({5'h00, irq_request}, 8'h04, "irq b only");
        wr(IDX_FLAG, 8'h07);
        $display("test interrupts done");

        // Clear-on-match: top 4 gives period 5, 12 ticks end at 2
        wr(IDX_CMP_A, 8'h04);
        wr(IDX_CMP_B, 8'h03);
        wr(IDX_COUNT, 8'h00);
        run(8'h09, 10);
        expect_reg(IDX_COUNT, 8'h02, "ctc count");
        expect_reg(IDX_FLAG, 8'h06, "ctc flags");
        wr(IDX_FLAG, 8'h07);
        $display("test clear on match done");

        // Count written equal to compare A: first match is swallowed
        wr(IDX_CMP_A, 8'h40);
        wr(IDX_COUNT, 8'h40);
        run(8'h01, 0);
        expect_reg(IDX_COUNT, 8'h42, "blocked count");
        expect_reg(IDX_FLAG, 8'h00, "blocked flags");
        // Compare write lands at once, then matches on the next pass
        wr(IDX_CMP_A, 8'h43);
        run(8'h01, 0);
        expect_reg(IDX_FLAG, 8'h02, "fresh compare");
        // Count write in a ticking cycle wins over the increment
        wr(IDX_CTRL, 8'h01);
        wr(IDX_COUNT, 8'h80);
        wr(IDX_CTRL, 8'h00);
        expect_reg(IDX_COUNT, 8'h82, "write priority");
        $display("test blocking done");

        // Pin edges: code 6 counts falls, code 7 counts rises
        for (int c = 6; c < 8; c++) begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_CTRL, 8'(c));
            for (int p = 0; p < 4; p++) begin
                count_pin <= 1'b1;
                repeat (4) @(posedge clk);
                count_pin <= 1'b0;
                repeat (4) @(posedge clk);
            end
            // Let the synchroniser latency drain before stopping
            repeat (6) @(posedge clk);
            wr(IDX_CTRL, 8'h00);
            expect_reg(IDX_COUNT, 8'h04, "pin edges");
        end
        $display("test pin done");

        // Prescaled sources: a window of div*4+1 edges holds 4 or 5 ticks
        for (int s = 0; s < 5; s++) begin
            wr(IDX_COUNT, 8'h00);
            run(8'(s + 1), divs[s] * 4 - 1);
            rd_reg(IDX_COUNT, rd);
            check({7'h00, (rd >= 8'h04 && rd <= 8'h05)}, 8'h01,
                  "divided ticks");
        end
        $display("test prescaler done");

        // Second reset in mid-run returns everything to zero
        wr(IDX_CTRL, 8'h01);
        do_reset();
        expect_reg(IDX_CTRL, 8'h00, "rereset ctrl");
        expect_reg(IDX_COUNT, 8'h00, "rereset count");
        $display("test second reset done");
        stop_test();
    end
endmodule
